/* File: hw/tpi_persist_chan.sv */
`timescale 1ns/1ns
`include "tpi_regs.svh"
module tpi_persist_chan #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Measurement
    input wire logic i_enable,
    input wire logic i_result_valid,
    input wire logic [WIDTH-1:0] i_result,
    input wire logic [WIDTH-1:0] i_low_level,
    input wire logic [WIDTH-1:0] i_high_level,
    input wire logic [5:0] i_target,
    // Event
    output logic o_event,
    output logic [5:0] o_count
);
    logic out_of_range;
    logic [5:0] count_r;
    logic event_r;

    assign out_of_range = (i_result < i_low_level) || (i_result > i_high_level);

    // ----------------------------------------
    // Counter, per channel
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_r <= 6'h00;
            event_r <= 1'b0;
        end else begin
            event_r <= 1'b0;
            if (!i_enable) begin
                count_r <= 6'h00;
            end else if (i_result_valid) begin
                if (i_target == 6'h00) begin
                    event_r <= 1'b1;
                end else if (!out_of_range) begin
                    count_r <= 6'h00;
                end else begin
                    if (count_r < 6'h3f) begin
                        count_r <= count_r + 6'h01;
                    end
                    if (({1'b0, count_r} + 7'h01) >= {1'b0, i_target}) begin
                        event_r <= 1'b1;
                    end
                end
            end
        end
    end

    assign o_event = event_r;
    assign o_count = count_r;
endmodule

/* File: hw/tpi_pkg.sv */
package tpi_pkg;
    typedef enum logic [1:0] {
        TPI_W_IDLE,
        TPI_W_COUNT
    } tpi_wait_state_t;
endpackage

/* File: hw/tpi_regs.svh */
`ifndef TPI_REGS_SVH
`define TPI_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TPI_OFF_PROX_LOW 8'h89
`define TPI_OFF_PROX_HIGH 8'h8b
`define TPI_OFF_PERSIST 8'h8c
`define TPI_OFF_CONFIG_ONE 8'h8d
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TPI_PROX_PERSIST_FIELD_MSB 7
`define TPI_PROX_PERSIST_FIELD_LSB 4
`define TPI_LIGHT_PERSIST_FIELD_MSB 3
`define TPI_LIGHT_PERSIST_FIELD_LSB 0
`define TPI_CFG1_WAIT_EXT 1
`define TPI_CFG1_LOWPWR 5
`define TPI_CFG1_RESET 8'h60
`define TPI_PROX_LOW_RESET 8'h00
`define TPI_PROX_HIGH_RESET 8'h00
`define TPI_PERSIST_RESET 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define TPI_WAIT_STEP_NS 2780000
`define TPI_CLK_PERIOD_NS 20
`define TPI_WAIT_EXT_FACTOR 12
`endif

/* File: hw/tpi_threshold_persistence_irq.sv */
`timescale 1ns/1ns
`include "tpi_regs.svh"
module tpi_threshold_persistence_irq
    import tpi_pkg::*;
#(
    parameter int WAIT_STEP_CYCLES = `TPI_WAIT_STEP_NS / `TPI_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Proximity channel
    input wire logic i_prox_enable,
    input wire logic i_prox_irq_enable,
    input wire logic i_prox_valid,
    input wire logic [7:0] i_prox_result,
    // Light channel
    input wire logic i_light_enable,
    input wire logic i_light_irq_enable,
    input wire logic i_light_valid,
    input wire logic [15:0] i_clear_channel_result,
    input wire logic [15:0] i_light_low_level,
    input wire logic [15:0] i_light_high_level,
    // Interrupt status
    input wire logic i_prox_irq_clear,
    input wire logic i_light_irq_clear,
    output logic o_prox_irq,
    output logic o_light_irq,
    // Wait timer
    input wire logic i_wait_start,
    input wire logic [7:0] i_wait_interval,
    output logic o_wait_busy,
    output logic o_wait_done,
    output logic o_wait_low_power
);
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;
    logic [7:0] prox_low_level_r;
    logic [7:0] prox_high_level_r;
    logic [7:0] persistence_filter_r;
    logic [7:0] config_one_r;
    logic [7:0] rdata_r;
    logic [3:0] prox_persist_field;
    logic [3:0] light_persist_field;
    logic [5:0] prox_target;
    logic [5:0] light_target;
    logic prox_event;
    logic light_event;
    logic prox_irq_r;
    logic light_irq_r;
    tpi_wait_state_t wait_state_r;
    logic [31:0] step_cnt_r;
    logic [8:0] steps_left_r;
    logic [3:0] ext_cnt_r;
    logic wait_done_r;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prox_low_level_r <= `TPI_PROX_LOW_RESET;
            prox_high_level_r <= `TPI_PROX_HIGH_RESET;
            persistence_filter_r <= `TPI_PERSIST_RESET;
            config_one_r <= `TPI_CFG1_RESET;
        end else if (i_reg_wr) begin
            unique case (i_reg_addr)
                `TPI_OFF_PROX_LOW: prox_low_level_r <= i_reg_wdata;
                `TPI_OFF_PROX_HIGH: prox_high_level_r <= i_reg_wdata;
                `TPI_OFF_PERSIST: persistence_filter_r <= i_reg_wdata;
                `TPI_OFF_CONFIG_ONE: config_one_r <= i_reg_wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else begin
            unique case (i_reg_addr)
                `TPI_OFF_PROX_LOW: rdata_r <= prox_low_level_r;
                `TPI_OFF_PROX_HIGH: rdata_r <= prox_high_level_r;
                `TPI_OFF_PERSIST: rdata_r <= persistence_filter_r;
                `TPI_OFF_CONFIG_ONE: rdata_r <= config_one_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end
    assign o_reg_rdata = rdata_r;

    // ----------------------------------------
    // Persistence targets
    // ----------------------------------------
    assign prox_persist_field = persistence_filter_r[`TPI_PROX_PERSIST_FIELD_MSB:`TPI_PROX_PERSIST_FIELD_LSB];
    assign light_persist_field = persistence_filter_r[`TPI_LIGHT_PERSIST_FIELD_MSB:`TPI_LIGHT_PERSIST_FIELD_LSB];
    assign prox_target = {2'b00, prox_persist_field};

    always_comb begin
        if (light_persist_field <= 4'h3) begin
            light_target = {2'b00, light_persist_field};
        end else begin
            light_target = 6'(({2'b00, light_persist_field} - 6'h03) * 6'h05);
        end
    end

    tpi_persist_chan #(
        .WIDTH(8)
    ) u_prox_chan (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_enable(i_prox_enable),
        .i_result_valid(i_prox_valid),
        .i_result(i_prox_result),
        .i_low_level(prox_low_level_r),
        .i_high_level(prox_high_level_r),
        .i_target(prox_target),
        .o_event(prox_event),
        .o_count()
    );

    tpi_persist_chan #(
        .WIDTH(16)
    ) u_light_chan (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_enable(i_light_enable),
        .i_result_valid(i_light_valid),
        .i_result(i_clear_channel_result),
        .i_low_level(i_light_low_level),
        .i_high_level(i_light_high_level),
        .i_target(light_target),
        .o_event(light_event),
        .o_count()
    );

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prox_irq_r <= 1'b0;
        end else if (prox_event && i_prox_irq_enable) begin
            prox_irq_r <= 1'b1;
        end else if (i_prox_irq_clear) begin
            prox_irq_r <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            light_irq_r <= 1'b0;
        end else if (light_event && i_light_irq_enable) begin
            light_irq_r <= 1'b1;
        end else if (i_light_irq_clear) begin
            light_irq_r <= 1'b0;
        end
    end
    assign o_prox_irq = prox_irq_r;
    assign o_light_irq = light_irq_r;

    // ----------------------------------------
    // Wait timer
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_state_r <= TPI_W_IDLE;
            step_cnt_r <= 32'h0000_0000;
            steps_left_r <= 9'h000;
            ext_cnt_r <= 4'h0;
            wait_done_r <= 1'b0;
        end else begin
            wait_done_r <= 1'b0;
            unique case (wait_state_r)
                TPI_W_IDLE: begin
                    if (i_wait_start) begin
                        wait_state_r <= TPI_W_COUNT;
                        step_cnt_r <= 32'h0000_0000;
                        steps_left_r <= 9'h100 - {1'b0, i_wait_interval};
                        ext_cnt_r <= 4'h0;
                    end
                end
                TPI_W_COUNT: begin
                    if (step_cnt_r == 32'(WAIT_STEP_CYCLES - 1)) begin
                        step_cnt_r <= 32'h0000_0000;
                        if (config_one_r[`TPI_CFG1_WAIT_EXT] &&
                            ext_cnt_r != 4'(`TPI_WAIT_EXT_FACTOR - 1)) begin
                            ext_cnt_r <= ext_cnt_r + 4'h1;
                        end else begin
                            ext_cnt_r <= 4'h0;
                            if (steps_left_r == 9'h001) begin
                                wait_state_r <= TPI_W_IDLE;
                                wait_done_r <= 1'b1;
                            end
                            steps_left_r <= steps_left_r - 9'h001;
                        end
                    end else begin
                        step_cnt_r <= step_cnt_r + 32'h0000_0001;
                    end
                end
                default: wait_state_r <= TPI_W_IDLE;
            endcase
        end
    end
    assign o_wait_busy = (wait_state_r == TPI_W_COUNT);
    assign o_wait_done = wait_done_r;
    assign o_wait_low_power = o_wait_busy && config_one_r[`TPI_CFG1_LOWPWR];
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
// ------
// Signals
// ------
localparam int WS = 4;
logic i_ref_clk = 0, i_rst_n = 0, i_reg_wr = 0, i_prox_valid = 0, i_light_valid = 0;
logic i_prox_enable = 1, i_prox_irq_enable = 1, i_light_enable = 1, i_light_irq_enable = 1;
logic i_prox_irq_clear = 0, i_light_irq_clear = 0, i_wait_start = 0;
logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_prox_result = 8'h00;
logic [7:0] i_wait_interval = 8'hff, o_reg_rdata, v;
logic [15:0] i_clear_channel_result = 16'h0000, i_light_low_level = 16'h1000;
logic [15:0] i_light_high_level = 16'hc000, d = 16'h0000;
logic [15:0] exp_q[$];
logic o_prox_irq, o_light_irq, o_wait_busy, o_wait_done, o_wait_low_power;
int sel_q[$];
int n_mismatch = 0, checks_done = 0, seed = 32'h7284a762, meas = 0, m0 = 0, s;
string nm[6] = '{"prox_irq", "light_irq", "reg_rdata", "low_power", "wait_delta", "wait_state"};
event ev;
tpi_threshold_persistence_irq #(.WAIT_STEP_CYCLES(WS)) i_tpi_threshold_persistence_irq (
    .i_ref_clk, .i_rst_n, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_prox_enable, .i_prox_irq_enable, .i_prox_valid, .i_prox_result,
    .i_light_enable, .i_light_irq_enable, .i_light_valid, .i_clear_channel_result,
    .i_light_low_level, .i_light_high_level, .i_prox_irq_clear, .i_light_irq_clear,
    .o_prox_irq, .o_light_irq, .i_wait_start, .i_wait_interval, .o_wait_busy,
    .o_wait_done, .o_wait_low_power
);
initial forever #10 i_ref_clk = ~i_ref_clk;
// ------
// Checking
// ------
function logic [15:0] obs(input int k);
    case (k)
        0: return {15'h0000, o_prox_irq};
        1: return {15'h0000, o_light_irq};
        2: return {8'h00, o_reg_rdata};
        3: return {15'h0000, o_wait_low_power};
        4: return d;
        default: return {14'h0000, o_wait_busy, o_wait_done};
    endcase
endfunction
task chk(input string n, input logic [15:0] seen, input logic [15:0] e);
    checks_done++;
    if (seen !== e) begin
        n_mismatch++;
        $display("MISMATCH %s expected %h seen %h", n, e, seen);
    end
endtask
task ex(input int k, input logic [15:0] e);
    sel_q.push_back(k);
    exp_q.push_back(e);
    ->ev;
endtask
initial forever begin
    @ev;
    while (sel_q.size() > 0) begin
        s = sel_q.pop_front();
        chk(nm[s], obs(s), exp_q.pop_front());
    end
end
task end_sim;
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
initial begin
    #400000;
    n_mismatch++;
    end_sim;
end
// ------
// Drivers
// ------
task cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
endtask
task wr(input logic [7:0] a, input logic [7:0] w);
    i_reg_addr = a;
    i_reg_wdata = w;
    i_reg_wr = 1;
    cyc(1);
    i_reg_wr = 0;
    cyc(1);
endtask
task rd(input logic [7:0] a, input logic [7:0] e);
    i_reg_addr = a;
    cyc(1);
    ex(2, {8'h00, e});
endtask
task clr;
    i_prox_irq_clear = 1;
    i_light_irq_clear = 1;
    cyc(1);
    i_prox_irq_clear = 0;
    i_light_irq_clear = 0;
endtask
task send(input int ch, input bit o);
    logic [15:0] r;
    r = 16'($random(seed));
    if (ch == 0) begin
        i_prox_result = o ? (r[15] ? (r[7:0] & 8'h3f) : 8'hc1 + {3'h0, r[4:0]}) :
            (r[15] ? 8'h40 : 8'hc0);
        i_prox_valid = 1;
    end else begin
        i_clear_channel_result = o ? (r[15] ? (r & 16'h0fff) : 16'hc001 + {3'h0, r[12:0]}) :
            (r[15] ? 16'h1000 : 16'hc000);
        i_light_valid = 1;
    end
    cyc(1);
    i_prox_valid = 0;
    i_light_valid = 0;
    cyc(2);
endtask
task run(input int ch, input int tgt);
    int k;
    k = (tgt == 0) ? 1 : tgt;
    send(ch, 0);
    clr;
    for (int i = 0; i < k; i++) begin
        send(ch, tgt != 0);
        ex(ch, {15'h0000, i == k - 1});
    end
endtask
task wt(input logic [7:0] cfg, input logic [7:0] n);
    wr(8'h8d, cfg);
    i_wait_interval = n;
    i_wait_start = 1;
    cyc(1);
    i_wait_start = 0;
    ex(3, {15'h0000, cfg[5]});
    ex(5, 16'h0002);
    meas = 0;
    while (!o_wait_done && meas < 3000) begin
        cyc(1);
        meas++;
    end
    ex(5, 16'h0001);
endtask
// ------
// Sequence
// ------
initial begin
    cyc(16);
    i_rst_n = 1;
    cyc(3);
    rd(8'h89, 8'h00);
    rd(8'h8b, 8'h00);
    rd(8'h8c, 8'h00);
    rd(8'h8d, 8'h60);
    rd(8'h8a, 8'h00);
    v = 8'($random(seed));
    wr(8'h89, v);
    rd(8'h89, v);
    v = 8'($random(seed));
    wr(8'h8b, v);
    rd(8'h8b, v);
    wr(8'h89, 8'h40);
    wr(8'h8b, 8'hc0);
    for (int c = 0; c < 16; c++) begin
        wr(8'h8c, {4'(c), 4'h0});
        run(0, c);
    end
    for (int c = 0; c < 16; c++) begin
        wr(8'h8c, {4'hf, 4'(c)});
        run(1, c < 4 ? c : (c - 3) * 5);
    end
    wr(8'h8c, 8'h22);
    send(0, 0);
    send(1, 0);
    clr;
    send(0, 1);
    send(1, 1);
    send(1, 1);
    ex(0, 16'h0000);
    ex(1, 16'h0001);
    clr;
    i_prox_irq_enable = 0;
    i_light_irq_enable = 0;
    send(0, 1);
    send(1, 1);
    ex(0, 16'h0000);
    ex(1, 16'h0000);
    i_prox_irq_enable = 1;
    i_light_irq_enable = 1;
    i_prox_enable = 0;
    i_light_enable = 0;
    cyc(1);
    i_prox_enable = 1;
    i_light_enable = 1;
    send(0, 1);
    send(1, 1);
    ex(0, 16'h0000);
    ex(1, 16'h0000);
    wt(8'h60, 8'hff);
    m0 = meas;
    wt(8'h62, 8'hff);
    d = 16'(meas - m0);
    ex(4, 16'(WS * 11));
    wt(8'h40, 8'hfe);
    d = 16'(meas - m0);
    ex(4, 16'(WS));
    cyc(3);
    end_sim;
end
endmodule

/* File: tb/tpi_threshold_persistence_irq_asserts.sv */
`timescale 1ns/1ns
// ------
// Port checker
// ------
module tpi_irq_asserts (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Channels
    input wire logic i_prox_valid,
    input wire logic i_prox_irq_enable,
    input wire logic i_prox_irq_clear,
    input wire logic o_prox_irq,
    input wire logic i_light_valid,
    input wire logic i_light_irq_enable,
    input wire logic i_light_irq_clear,
    input wire logic o_light_irq,
    // Wait timer and registers
    input wire logic i_wait_start,
    input wire logic o_wait_busy,
    input wire logic o_wait_done,
    input wire logic o_wait_low_power,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] o_reg_rdata
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    a_prox_irq_cause: assert property ($rose(o_prox_irq) |-> $past(i_prox_valid, 2))
        else $error("prox irq rose with no result");
    a_light_irq_cause: assert property ($rose(o_light_irq) |-> $past(i_light_valid, 2))
        else $error("light irq rose with no result");
    a_prox_irq_gate: assert property ($rose(o_prox_irq) |->
        $past(i_prox_irq_enable) || $past(i_prox_irq_enable, 2)) else $error("prox irq ungated");
    a_light_irq_gate: assert property ($rose(o_light_irq) |->
        $past(i_light_irq_enable) || $past(i_light_irq_enable, 2)) else $error("light irq ungated");
    a_prox_irq_holds: assert property (o_prox_irq && !i_prox_irq_clear |=> o_prox_irq)
        else $error("prox irq dropped");
    a_light_irq_holds: assert property (o_light_irq && !i_light_irq_clear |=> o_light_irq)
        else $error("light irq dropped");
    a_wait_low_power: assert property (o_wait_low_power |-> o_wait_busy)
        else $error("low power outside wait");
    a_wait_start_busy: assert property (i_wait_start && !o_wait_busy |=> o_wait_busy)
        else $error("wait did not start");
    a_wait_done_pulse: assert property (o_wait_done |=> !o_wait_done)
        else $error("wait done too long");
    a_unmapped_read: assert property (!(i_reg_addr inside {8'h89, 8'h8b, 8'h8c, 8'h8d}) |=>
        o_reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind tpi_threshold_persistence_irq tpi_irq_asserts i_tpi_irq_asserts (
    .i_ref_clk, .i_rst_n, .i_prox_valid, .i_prox_irq_enable, .i_prox_irq_clear, .o_prox_irq,
    .i_light_valid, .i_light_irq_enable, .i_light_irq_clear, .o_light_irq, .i_wait_start,
    .o_wait_busy, .o_wait_done, .o_wait_low_power, .i_reg_addr, .o_reg_rdata
);
